// ### reader_command_status_page.v
`include "reader_page_map.vh"
`timescale 1ns/1ps
`default_nettype none

module reader_command_status_page
#(
  parameter DEPTH         = `QUEUE_DEPTH,
  parameter AW            = 6,
  parameter DETECT_CYCLES = `DETECT_CYCLES
)
(
  input  wire       clk,
  input  wire       rst,
  input  wire [5:0] bus_addr,
  input  wire [7:0] bus_data_in,
  output reg  [7:0] bus_data_out,
  output reg        bus_data_oe_n,
  input  wire       bus_wr_n,
  input  wire       bus_rd_n,
  output reg  [5:0] resolved_addr,
  output reg  [5:0] command_code,
  output reg        command_start,
  input  wire       command_done,
  input  wire [2:0] link_state_in,
  input  wire [5:0] irq_request,
  input  wire [5:0] irq_enable,
  input  wire [7:0] error_flags,
  input  wire [5:0] alert_threshold,
  input  wire [7:0] rx_byte,
  input  wire       rx_valid,
  output reg        rx_ready,
  output reg  [7:0] tx_byte,
  output reg        tx_valid,
  input  wire       tx_ready,
  output reg  [6:0] queue_byte_count,
  output reg  [7:0] primary_state_flags
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  reg [5:0] addr_s1;
  reg [5:0] addr_s2;
  reg [7:0] data_s1;
  reg [7:0] data_s2;
  reg       wr_n_s1;
  reg       wr_n_s2;
  reg       wr_n_d;
  reg       rd_n_s1;
  reg       rd_n_s2;
  reg       rd_n_d;

  always @(posedge clk)
  begin
    if (rst)
    begin
      addr_s1 <= 6'h00;
      addr_s2 <= 6'h00;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
      wr_n_s1 <= 1'b1;
      wr_n_s2 <= 1'b1;
      wr_n_d  <= 1'b1;
      rd_n_s1 <= 1'b1;
      rd_n_s2 <= 1'b1;
      rd_n_d  <= 1'b1;
    end
    else
    begin
      addr_s1 <= bus_addr;
      addr_s2 <= addr_s1;
      data_s1 <= bus_data_in;
      data_s2 <= data_s1;
      wr_n_s1 <= bus_wr_n;
      wr_n_s2 <= wr_n_s1;
      wr_n_d  <= wr_n_s2;
      rd_n_s1 <= bus_rd_n;
      rd_n_s2 <= rd_n_s1;
      rd_n_d  <= rd_n_s2;
    end
  end

  wire host_wr = wr_n_d & ~wr_n_s2;
  wire host_rd = rd_n_d & ~rd_n_s2;

  // --------------------------------------------------------------------------
  // address forming
  // --------------------------------------------------------------------------
  reg [7:0] page_select;

  function [5:0] form_addr;
    input [7:0] page;
    input [5:0] latched;
    begin
      if (page[`PAGE_OVERRIDE_BIT])
        form_addr = {page[`PAGE_NUMBER_MSB:0], latched[2:0]};
      else
        form_addr = latched;
    end
  endfunction

  wire [5:0] eff_addr  = form_addr(page_select, addr_s2);
  wire       hit_page  = (eff_addr[2:0] == `PAGE_SELECT_LOW);
  wire       hit_cmd   = (eff_addr == `COMMAND_LAUNCH_OFS);
  wire       hit_data  = (eff_addr == `QUEUE_DATA_OFS);
  wire       hit_stat  = (eff_addr == `PRIMARY_FLAGS_OFS);

  // --------------------------------------------------------------------------
  // host port detection
  // --------------------------------------------------------------------------
  reg [15:0] detect_cnt;
  reg        detect_pending;

  always @(posedge clk)
  begin
    if (rst)
    begin
      detect_cnt     <= 16'h0000;
      detect_pending <= 1'b1;
    end
    else if (detect_pending)
    begin
      detect_cnt <= detect_cnt + 16'h0001;
      if (detect_cnt == DETECT_CYCLES[15:0] - 16'h0001)
        detect_pending <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // page select and command registers
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      page_select   <= `PAGE_SELECT_RST;
      command_code  <= `COMMAND_IDLE;
      command_start <= 1'b0;
    end
    else
    begin
      command_start <= 1'b0;
      if (command_done)
        command_code <= `COMMAND_IDLE;
      if (host_wr && hit_page)
        page_select <= {data_s2[7], 4'h0, data_s2[2:0]};
      if (host_wr && hit_cmd)
      begin
        command_code  <= data_s2[`COMMAND_MSB:0];
        command_start <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // data queue
  // --------------------------------------------------------------------------
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg           wr_pend;
  reg  [7:0]    wr_pend_data;
  reg           rd_pend;
  reg           moved;
  reg  [7:0]    skid1;
  reg           skid1_valid;
  wire [7:0]    mem_q;
  reg  [6:0]    next_count;

  wire settled   = ~moved;
  wire rx_push   = rx_valid & rx_ready;
  wire host_push = wr_pend & ~rx_push &
                   (queue_byte_count < DEPTH[6:0]);
  wire push      = rx_push | host_push;
  wire [7:0] push_data = rx_push ? rx_byte : wr_pend_data;
  wire nonempty  = (queue_byte_count != 7'h00);
  wire host_pop  = rd_pend & settled & nonempty;
  wire drain_pop = ~rd_pend & settled & nonempty & ~skid1_valid &
                   ~(tx_valid & ~tx_ready);
  wire pop       = host_pop | drain_pop;
  wire tx_take   = tx_valid & tx_ready;

  always @*
  begin
    next_count = queue_byte_count;
    if (push & ~pop)
      next_count = queue_byte_count + 7'h01;
    else if (pop & ~push)
      next_count = queue_byte_count - 7'h01;
  end

  queue_store
  #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  )
  u_store
  (
    .clk     (clk),
    .wr_en   (push),
    .wr_addr (wr_ptr),
    .wr_data (push_data),
    .rd_addr (rd_ptr),
    .rd_data (mem_q)
  );

  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr           <= {AW{1'b0}};
      rd_ptr           <= {AW{1'b0}};
      queue_byte_count <= 7'h00;
      wr_pend          <= 1'b0;
      wr_pend_data     <= 8'h00;
      rd_pend          <= 1'b0;
      moved            <= 1'b0;
      rx_ready         <= 1'b0;
    end
    else
    begin
      moved            <= push | pop;
      queue_byte_count <= next_count;
      rx_ready         <= (next_count < DEPTH[6:0] - 7'h01);
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (host_wr && hit_data)
      begin
        wr_pend      <= 1'b1;
        wr_pend_data <= data_s2;
      end
      else if (~rx_push)
        wr_pend <= 1'b0;
      if (host_rd && hit_data)
        rd_pend <= 1'b1;
      else if (settled)
        rd_pend <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // single-byte buffer toward the transmitter (skid1_valid is never set)
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      skid1       <= 8'h00;
      skid1_valid <= 1'b0;
      tx_valid    <= 1'b0;
      tx_byte     <= 8'h00;
    end
    else
    begin
      if (tx_take)
      begin
        if (skid1_valid)
        begin
          tx_byte     <= skid1;
          skid1_valid <= drain_pop;
          skid1       <= mem_q;
        end
        else if (drain_pop)
          tx_byte <= mem_q;
        else
          tx_valid <= 1'b0;
      end
      else if (drain_pop)
      begin
        if (tx_valid)
        begin
          skid1       <= mem_q;
          skid1_valid <= 1'b1;
        end
        else
        begin
          tx_byte  <= mem_q;
          tx_valid <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // primary status
  // --------------------------------------------------------------------------
  wire [6:0] free_space = DEPTH[6:0] - queue_byte_count;
  wire [6:0] threshold  = {1'b0, alert_threshold};

  always @(posedge clk)
  begin
    if (rst)
    begin
      primary_state_flags <= `PRIMARY_FLAGS_RST;
    end
    else
    begin
      primary_state_flags[7] <= 1'b0;
      primary_state_flags[`LINK_STATE_MSB:`LINK_STATE_LSB]
        <= link_state_in;
      primary_state_flags[`IRQ_SUMMARY_BIT]
        <= |(irq_request & irq_enable);
      primary_state_flags[`ERR_SUMMARY_BIT]
        <= |error_flags;
      primary_state_flags[`NEARLY_FULL_BIT]
        <= (free_space <= threshold);
      primary_state_flags[`NEARLY_EMPTY_BIT]
        <= (queue_byte_count <= threshold);
    end
  end

  // --------------------------------------------------------------------------
  // host read path
  // --------------------------------------------------------------------------
  reg data_read_wait;

  always @(posedge clk)
  begin
    if (rst)
    begin
      bus_data_out   <= 8'h00;
      bus_data_oe_n  <= 1'b1;
      resolved_addr  <= 6'h00;
      data_read_wait <= 1'b0;
    end
    else
    begin
      resolved_addr <= eff_addr;
      bus_data_oe_n <= rd_n_s2;
      if (host_rd)
      begin
        data_read_wait <= hit_data;
        if (hit_page)
          bus_data_out <= page_select;
        else if (hit_cmd)
          bus_data_out <= {detect_pending, 1'b0,
                           command_code};
        else if (hit_stat)
          bus_data_out <= primary_state_flags;
        else
          bus_data_out <= 8'h00;
      end
      else if (data_read_wait && host_pop)
      begin
        bus_data_out   <= mem_q;
        data_read_wait <= 1'b0;
      end
      else if (data_read_wait && settled && !nonempty)
      begin
        bus_data_out   <= 8'h00;
        data_read_wait <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### reader_page_map.vh
`ifndef READER_PAGE_MAP_VH
`define READER_PAGE_MAP_VH

// ----------------------------------------------------------------------------
// register offsets (page select decoded from the low three bits, the others from the whole effective address)
// ----------------------------------------------------------------------------
`define PAGE_SELECT_LOW     3'h0
`define COMMAND_LAUNCH_OFS  6'h01
`define QUEUE_DATA_OFS      6'h02
`define PRIMARY_FLAGS_OFS   6'h03

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PAGE_SELECT_RST     8'h80
`define PRIMARY_FLAGS_RST   8'h05
`define COMMAND_IDLE        6'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PAGE_OVERRIDE_BIT   7
`define PAGE_NUMBER_MSB     2
`define DETECT_PENDING_BIT  7
`define COMMAND_MSB         5
`define LINK_STATE_MSB      6
`define LINK_STATE_LSB      4
`define IRQ_SUMMARY_BIT     3
`define ERR_SUMMARY_BIT     2
`define NEARLY_FULL_BIT     1
`define NEARLY_EMPTY_BIT    0

// ----------------------------------------------------------------------------
// link state codes
// ----------------------------------------------------------------------------
`define LINK_IDLE           3'h0
`define LINK_FRAME_START    3'h1
`define LINK_PAYLOAD        3'h2
`define LINK_FRAME_END      3'h3
`define LINK_RX_TRANSITION  3'h4
`define LINK_RX_GUARD_WAIT  3'h5
`define LINK_RX_LISTEN      3'h6
`define LINK_RECEIVING      3'h7

// ----------------------------------------------------------------------------
// queue and timing
// ----------------------------------------------------------------------------
`define QUEUE_DEPTH         64
`define CLK_PERIOD_NS       50
`define DETECT_TIME_NS      1000
`define DETECT_CYCLES \
  ((`DETECT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### queue_store.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// byte store of the data queue, registered read
// ----------------------------------------------------------------------------
module queue_store
#(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW    = 6
)
(
  input  wire             clk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// ### reader_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// host processor on the parallel bus
// ----
module reader_host_model
(
  input  wire logic       clk,
  input  wire logic [7:0] bus_data_out,
  input  wire logic       bus_data_oe_n,
  output var  logic [5:0] bus_addr,
  output wire logic [7:0] bus_data_in,
  output var  logic       bus_wr_n,
  output var  logic       bus_rd_n
);
  logic [7:0] drv;
  logic       drive;
  // a released bus shows the inverse of the last value
  assign bus_data_in = !bus_data_oe_n ? bus_data_out : drive ? drv : ~drv;
  initial
  begin
    bus_addr = 6'h00;
    drv = 8'h00;
    drive = 1'b0;
    bus_wr_n = 1'b1;
    bus_rd_n = 1'b1;
  end
  task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    drv = d;
    drive = 1'b1;
    repeat (4) @(negedge clk);
    bus_wr_n = 1'b0;
    repeat (6) @(negedge clk);
    bus_wr_n = 1'b1;
    repeat (4) @(negedge clk);
    drive = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic bus_read(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    repeat (4) @(negedge clk);
    bus_rd_n = 1'b0;
    repeat (8) @(negedge clk);
    d = bus_data_in;
    bus_rd_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### reader_command_status_page_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module reader_command_status_page_asserts
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       bus_rd_n,
  input wire logic       bus_data_oe_n,
  input wire logic [5:0] command_code,
  input wire logic       command_start,
  input wire logic       command_done,
  input wire logic [2:0] link_state_in,
  input wire logic [5:0] irq_request,
  input wire logic [5:0] irq_enable,
  input wire logic [7:0] error_flags,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [6:0] queue_byte_count,
  input wire logic [7:0] primary_state_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // sequences
  // ----
  sequence tx_stalled;
    tx_valid && !tx_ready;
  endsequence
  sequence tx_kept;
    tx_valid && $stable(tx_byte);
  endsequence
  a_start_pulse: assert property (command_start |=> !command_start)
    else $error("command start longer than one cycle");
  a_code_done: assert property (command_done |=> command_code == 6'h00)
    else $error("command code not cleared on done");
  a_link_mirror: assert property (!$past(rst) |->
    primary_state_flags[6:4] == $past(link_state_in))
    else $error("link state field wrong");
  a_irq_summary: assert property (!$past(rst) |->
    primary_state_flags[3] == |$past(irq_request & irq_enable))
    else $error("interrupt summary wrong");
  a_err_summary: assert property (!$past(rst) |->
    primary_state_flags[2] == |$past(error_flags))
    else $error("error summary wrong");
  a_status_reserved: assert property (primary_state_flags[7] == 1'b0)
    else $error("status bit 7 set");
  a_count_step: assert property (!$past(rst) |->
    queue_byte_count <= $past(queue_byte_count) + 7'd1 &&
    queue_byte_count + 7'd1 >= $past(queue_byte_count))
    else $error("byte count jumped");
  a_count_bound: assert property (queue_byte_count <= 7'd64)
    else $error("byte count above depth");
  a_tx_hold: assert property (tx_stalled |=> tx_kept)
    else $error("tx byte dropped while stalled");
  a_oe_drive: assert property ($fell(bus_rd_n) |-> ##[1:4] !bus_data_oe_n)
    else $error("data bus not driven on read");
  a_oe_release: assert property (bus_rd_n [*4] |-> bus_data_oe_n)
    else $error("data bus driven without read");
endmodule
`default_nettype wire

// ### reader_command_status_page_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define cmp(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module reader_command_status_page_tb;
  logic clk, rst, command_done, rx_valid, tx_ready, took, bus_wr_n, bus_rd_n;
  logic [2:0] link_state_in;
  logic [5:0] irq_request, irq_enable, alert_threshold, bus_addr;
  logic [5:0] resolved_addr, command_code;
  logic [7:0] error_flags, rx_byte, d, bus_data_in, bus_data_out, tx_byte;
  logic [7:0] primary_state_flags, exp_q[$];
  logic [6:0] queue_byte_count;
  logic bus_data_oe_n, command_start, rx_ready, tx_valid;
  int failures = 0;
  int samples_checked = 0;
  reader_command_status_page #(.DETECT_CYCLES(40)) dut_u (.clk, .rst,
    .bus_addr, .bus_data_in, .bus_data_out, .bus_data_oe_n, .bus_wr_n,
    .bus_rd_n, .resolved_addr, .command_code, .command_start, .command_done,
    .link_state_in, .irq_request, .irq_enable, .error_flags, .alert_threshold,
    .rx_byte, .rx_valid, .rx_ready, .tx_byte, .tx_valid, .tx_ready,
    .queue_byte_count, .primary_state_flags);
  reader_host_model host_u (.clk, .bus_data_out, .bus_data_oe_n, .bus_addr,
    .bus_data_in, .bus_wr_n, .bus_rd_n);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----
  // queue traffic monitor
  // ----
  always @(posedge clk)
  begin
    took <= rx_valid && rx_ready;
    if (rx_valid && rx_ready) exp_q.push_back(rx_byte);
    if (tx_valid && tx_ready)
    begin
      `cmp("tx_byte", exp_q[0], tx_byte)
      exp_q.delete(0);
    end
  end
  task give_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task t_detect;
    int i;
    host_u.bus_read(6'h01, d);
    `cmp("cmd_busy", 8'h80, d)
    for (i = 0; i < 10 && d[7] !== 1'b0; i++) host_u.bus_read(6'h01, d);
    if (i == 10)
    begin
      failures++;
      give_verdict();
    end
    `cmp("cmd_ready", 8'h00, d)
    $display("test detect done");
  endtask
  task t_command;
    host_u.bus_write(6'h01, 8'hff);
    `cmp("command_code", 6'h3f, command_code)
    host_u.bus_read(6'h01, d);
    `cmp("cmd_read", 8'h3f, d)
    @(negedge clk) command_done = 1'b1;
    @(negedge clk) command_done = 1'b0;
    host_u.bus_read(6'h01, d);
    `cmp("cmd_done", 8'h00, d)
    $display("test command done");
  endtask
  task t_page;
    int p;
    host_u.bus_read(6'h08, d);
    `cmp("page_reset", 8'h80, d)
    for (p = 0; p < 8; p++)
    begin
      host_u.bus_write(6'h00, 8'hf8 | p[7:0]);
      host_u.bus_read(6'h00, d);
      `cmp("page_read", 8'h80 | p[7:0], d)
      host_u.bus_read(6'h03, d);
      `cmp("resolved_on", {p[2:0], 3'h3}, resolved_addr)
    end
    host_u.bus_write(6'h00, 8'h00);
    host_u.bus_read(6'h2b, d);
    `cmp("resolved_off", 6'h2b, resolved_addr)
    `cmp("unmapped", 8'h00, d)
    host_u.bus_read(6'h38, d);
    `cmp("page_38", 8'h00, d)
    host_u.bus_write(6'h38, 8'h80);
    $display("test page done");
  endtask
  task t_status;
    int s;
    alert_threshold = 6'd0;
    irq_enable = 6'h04;
    for (s = 0; s < 8; s++)
    begin
      link_state_in = s[2:0];
      irq_request = {3'h0, s[2:0]};
      error_flags = s[0] ? 8'h80 : 8'h00;
      host_u.bus_read(6'h03, d);
      `cmp("status", {1'b0, s[2:0], s[2], s[0], 2'b01}, d)
    end
    $display("test status done");
  endtask
  task t_queue;
    int i;
    alert_threshold = 6'd4;
    // the first byte moves on into the stalled transmit buffer
    for (i = 0; i < 6; i++)
    begin
      host_u.bus_write(6'h02, 8'ha0 + i[7:0]);
      exp_q.push_back(8'ha0 + i[7:0]);
      if (i == 4) host_u.bus_read(6'h03, d);
    end
    `cmp("lo_at_4", 1'b1, d[0])
    host_u.bus_read(6'h03, d);
    `cmp("lo_at_5", 1'b0, d[0])
    `cmp("count_wr", 7'd5, queue_byte_count)
    host_u.bus_read(6'h02, d);
    `cmp("pop", 8'ha1, d)
    exp_q.delete(1);
    `cmp("count_rd", 7'd4, queue_byte_count)
    rx_byte = 8'h10;
    rx_valid = 1'b1;
    for (i = 0; i < 100 && queue_byte_count !== 7'd63; i++)
      @(negedge clk) if (took) rx_byte = rx_byte + 8'h01;
    if (i == 100)
    begin
      failures++;
      give_verdict();
    end
    rx_valid = 1'b0;
    repeat (2) @(negedge clk);
    `cmp("rx_ready_full", 1'b0, rx_ready)
    host_u.bus_read(6'h03, d);
    `cmp("hi_full", 1'b1, d[1])
    for (i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clk) tx_ready = i[0];
    if (i == 400)
    begin
      failures++;
      give_verdict();
    end
    tx_ready = 1'b0;
    `cmp("drained", 0, exp_q.size())
    host_u.bus_read(6'h02, d);
    `cmp("empty_read", 8'h00, d)
    `cmp("count_empty", 7'd0, queue_byte_count)
    $display("test queue done");
  endtask
  initial
  begin
    rst = 1'b1;
    command_done = 1'b0;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    link_state_in = 3'h0;
    irq_request = 6'h00;
    irq_enable = 6'h00;
    alert_threshold = 6'h00;
    error_flags = 8'h00;
    rx_byte = 8'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_detect();
    t_command();
    t_page();
    t_status();
    t_queue();
    give_verdict();
  end
endmodule
bind reader_command_status_page reader_command_status_page_asserts chk_u (
  .clk, .rst, .bus_rd_n, .bus_data_oe_n, .command_code, .command_start,
  .command_done, .link_state_in, .irq_request, .irq_enable, .error_flags,
  .tx_byte, .tx_valid, .tx_ready, .queue_byte_count, .primary_state_flags);
`undef cmp
`default_nettype wire
